// ### inc/eim_pkg.sv
// Purpose: Shared constants and carrier types for the E1 mask, pulse and error insertion bank.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Summary of operation follows.
// Summary of operation
// - Masked multiframe sync loss raises vector 10000000.
// - Masked CRC-4 multiframe loss raises vector 10000000.
// - Masked remote multiframe alarm raises vector 10000000.
// - One-second flag rise raises vector 00001000.
// - Timer A flag rise raises vector 00001000.
// - Timer B flag rise raises vector 00001000.
// - Mask bits reset masked; one unmasks.
// - Custom select picks coefficients, else preset.
// - Page two decodes five address bits.
// - Rising bit 7 inserts one bipolar violation.
// - Rising bit 6 inserts one CRC-4 error.
// - Rising bit 5 corrupts one alignment signal.
// - Rising bit 4 flips one non-alignment bit two.
// - Bit 3 high forces all-zero transmit.
// - Rising bit 2 inserts one payload error.
// - Steady or falling insertion bits do nothing.
// - Debounce select gives 14 ms or none.
// - Debounce may stretch up to 2 ms.
`default_nettype none

package eim_pkg;
  // ----------------------------------------
  // Pages and addresses
  // ----------------------------------------
  localparam logic [2:0] PAGE_MASK = 3'h1;
  localparam logic [2:0] PAGE_CTRL2 = 3'h2;
  localparam logic [4:0] ADDR_IRQ_MASK3 = 5'h1E;
  localparam logic [4:0] ADDR_TX_PULSE = 5'h1F;
  localparam logic [4:0] ADDR_ERR_DBNC = 5'h10;
  localparam logic [4:0] ADDR_ACCESS = 5'h13;
  localparam logic [4:0] ADDR_JITTER = 5'h18;
  localparam logic [4:0] ADDR_RX_EQ = 5'h19;
  localparam logic [4:0] ADDR_RSVD_A = 5'h1A;
  localparam logic [4:0] ADDR_RSVD_B = 5'h1B;
  localparam logic [4:0] ADDR_COEF_A = 5'h1C;
  localparam logic [4:0] ADDR_COEF_B = 5'h1D;
  localparam logic [4:0] ADDR_COEF_C = 5'h1E;
  localparam logic [4:0] ADDR_COEF_D = 5'h1F;
  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int MFSYNC_BIT = 7;
  localparam int CRC_MFSYNC_BIT = 6;
  localparam int REMOTE_MF_BIT = 4;
  localparam int ONE_SEC_BIT = 3;
  localparam int TIMER_A_BIT = 2;
  localparam int TIMER_B_BIT = 1;
  localparam int CUSTOM_SEL_BIT = 3;
  localparam int LINE_VIOL_BIT = 7;
  localparam int CRC_ERR_BIT = 6;
  localparam int ALIGN_ERR_BIT = 5;
  localparam int NONALIGN_ERR_BIT = 4;
  localparam int NO_PULSE_BIT = 3;
  localparam int PAYLOAD_ERR_BIT = 2;
  localparam int DEBOUNCE_SEL_BIT = 0;
  localparam logic [7:0] IRQ_MASK3_WMASK = 8'hDE;
  localparam logic [7:0] ERR_DBNC_WMASK = 8'hFD;
  localparam logic [7:0] COEF_WMASK = 8'h7F;
  localparam logic [7:0] VEC_SYNC = 8'h80;
  localparam logic [7:0] VEC_TIMING = 8'h08;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEBOUNCE_MS = 14;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_CNT_W = 21;
  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] page;
    logic [4:0] addr;
    logic [7:0] data;
  } eim_host_req_t;

  typedef struct packed {
    logic line_slot;
    logic crc_slot;
    logic align_slot;
    logic nonalign_slot;
    logic payload_slot;
  } eim_tx_slots_t;
endpackage

`default_nettype wire

// ### hdl/eim_bank.sv
// Purpose: Register bank for interrupt mask three, transmit pulse control and error insertion.
// Assumes: Host port signals and framer events are synchronous to ref_clk.
// Notes: Read data is registered one cycle after a read strobe.
`default_nettype none

module eim_bank #(
  parameter int DEBOUNCE_LEN = eim_pkg::DEBOUNCE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire eim_pkg::eim_host_req_t host_req,
  output logic [7:0] rd_data_ff,
  input wire logic mfsync_lost,
  input wire logic crc_mfsync_lost,
  input wire logic remote_mf_alarm,
  input wire logic one_second_flag,
  input wire logic timer_a_flag,
  input wire logic timer_b_flag,
  input wire logic irq_ack,
  output logic irq_ff,
  output logic [7:0] irq_vector_ff,
  output logic custom_pulse_sel,
  output logic [2:0] preset_pulse_level,
  output logic [6:0] pulse_coef_a,
  output logic [6:0] pulse_coef_b,
  output logic [6:0] pulse_coef_c,
  output logic [6:0] pulse_coef_d,
  input wire eim_pkg::eim_tx_slots_t tx_slots,
  output logic insert_line_violation,
  output logic insert_crc_error,
  output logic insert_align_error,
  output logic insert_nonalign_error,
  output logic insert_payload_error,
  output logic force_no_pulses,
  output logic [7:0] access_ctrl_out,
  output logic [7:0] jitter_ctrl_out,
  output logic [7:0] rx_eq_ctrl_out,
  input wire logic sig_mf_tick,
  input wire logic [3:0] sig_raw,
  output logic [3:0] sig_debounced_ff
);
  import eim_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // A rising write: the new value is one while the held value is zero.
  function automatic logic rose(input logic new_bit, input logic old_bit);
    rose = new_bit & ~old_bit;
  endfunction

  // Page and address match; gated with wr it forms a write strobe, alone it selects the read word.
  function automatic logic hit(input eim_host_req_t r, input logic [2:0] pg, input logic [4:0] ad);
    hit = (r.page == pg) && (r.addr == ad);
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] irq_mask3_ff;
  logic [7:0] tx_pulse_ff;
  logic [7:0] err_dbnc_ff;
  logic [7:0] access_ff;
  logic [7:0] jitter_ff;
  logic [7:0] rx_eq_ff;
  logic [7:0] rsvd_a_ff;
  logic [7:0] rsvd_b_ff;
  logic [7:0] coef_a_ff;
  logic [7:0] coef_b_ff;
  logic [7:0] coef_c_ff;
  logic [7:0] coef_d_ff;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // page decode
  // Page two uses all five address bits; the gaps at 11H, 12H and 14H-17H hold nothing.
  wire wr_mask3 = host_req.wr & hit(host_req, PAGE_MASK, ADDR_IRQ_MASK3);
  wire wr_txp = host_req.wr & hit(host_req, PAGE_MASK, ADDR_TX_PULSE);
  wire wr_err = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_ERR_DBNC);
  wire wr_acc = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_ACCESS);
  wire wr_jit = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_JITTER);
  wire wr_req = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_RX_EQ);
  wire wr_rsa = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_RSVD_A);
  wire wr_rsb = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_RSVD_B);
  wire wr_cfa = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_COEF_A);
  wire wr_cfb = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_COEF_B);
  wire wr_cfc = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_COEF_C);
  wire wr_cfd = host_req.wr & hit(host_req, PAGE_CTRL2, ADDR_COEF_D);

  // Read mux; an unmapped location answers zero.
  logic [7:0] nxt_rd_data;
  always_comb begin
    nxt_rd_data = 8'h00;
    if (hit(host_req, PAGE_MASK, ADDR_IRQ_MASK3)) nxt_rd_data = irq_mask3_ff;
    else if (hit(host_req, PAGE_MASK, ADDR_TX_PULSE)) nxt_rd_data = tx_pulse_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_ERR_DBNC)) nxt_rd_data = err_dbnc_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_ACCESS)) nxt_rd_data = access_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_JITTER)) nxt_rd_data = jitter_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_RX_EQ)) nxt_rd_data = rx_eq_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_RSVD_A)) nxt_rd_data = rsvd_a_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_RSVD_B)) nxt_rd_data = rsvd_b_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_COEF_A)) nxt_rd_data = coef_a_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_COEF_B)) nxt_rd_data = coef_b_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_COEF_C)) nxt_rd_data = coef_c_ff;
    else if (hit(host_req, PAGE_CTRL2, ADDR_COEF_D)) nxt_rd_data = coef_d_ff;
  end

  // Read data holds its last value between read strobes.
  always_ff @(posedge ref_clk) begin
    if (rst) rd_data_ff <= 8'h00;
    else if (host_req.rd) rd_data_ff <= nxt_rd_data;
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------

  // masked at reset
  // Unused mask bits 5 and 0 are never stored, so they read zero.
  always_ff @(posedge ref_clk) begin
    if (rst) irq_mask3_ff <= REG_RESET;
    else if (wr_mask3) irq_mask3_ff <= host_req.data & IRQ_MASK3_WMASK;
  end

  // upper bits kept
  // The top nibble is stored as written; only the host keeps it clear.
  always_ff @(posedge ref_clk) begin
    if (rst) tx_pulse_ff <= REG_RESET;
    else if (wr_txp) tx_pulse_ff <= host_req.data;
  end

  // stored for comparison
  // The held error word is the previous value the next write is compared with.
  always_ff @(posedge ref_clk) begin
    if (rst) err_dbnc_ff <= REG_RESET;
    else if (wr_err) err_dbnc_ff <= host_req.data & ERR_DBNC_WMASK;
  end

  // Control words owned by neighbouring blocks; only storage lives here.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      access_ff <= REG_RESET;
      jitter_ff <= REG_RESET;
      rx_eq_ff <= REG_RESET;
    end else begin
      if (wr_acc) access_ff <= host_req.data;
      if (wr_jit) jitter_ff <= host_req.data;
      if (wr_req) rx_eq_ff <= host_req.data;
    end
  end

  // reserved storage
  // Reserved words read back what was written so software can verify zeros.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsvd_a_ff <= REG_RESET;
      rsvd_b_ff <= REG_RESET;
    end else begin
      if (wr_rsa) rsvd_a_ff <= host_req.data;
      if (wr_rsb) rsvd_b_ff <= host_req.data;
    end
  end

  // Coefficients are seven bits wide; bit 7 reads zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      coef_a_ff <= REG_RESET;
      coef_b_ff <= REG_RESET;
      coef_c_ff <= REG_RESET;
      coef_d_ff <= REG_RESET;
    end else begin
      if (wr_cfa) coef_a_ff <= host_req.data & COEF_WMASK;
      if (wr_cfb) coef_b_ff <= host_req.data & COEF_WMASK;
      if (wr_cfc) coef_c_ff <= host_req.data & COEF_WMASK;
      if (wr_cfd) coef_d_ff <= host_req.data & COEF_WMASK;
    end
  end

  // ----------------------------------------
  // Transmit pulse level selection
  // ----------------------------------------

  // pulse source select
  // The line driver reads the preset field when custom select is low, else the coefficients.
  assign custom_pulse_sel = tx_pulse_ff[CUSTOM_SEL_BIT];
  assign preset_pulse_level = tx_pulse_ff[2:0];
  assign pulse_coef_a = coef_a_ff[6:0];
  assign pulse_coef_b = coef_b_ff[6:0];
  assign pulse_coef_c = coef_c_ff[6:0];
  assign pulse_coef_d = coef_d_ff[6:0];
  assign access_ctrl_out = access_ff;
  assign jitter_ctrl_out = jitter_ff;
  assign rx_eq_ctrl_out = rx_eq_ff;

  // ----------------------------------------
  // Interrupt vector generation
  // ----------------------------------------
  logic one_sec_q_ff;
  logic timer_a_q_ff;
  logic timer_b_q_ff;

  // Flag history for the zero-to-one detectors.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      one_sec_q_ff <= 1'b0;
      timer_a_q_ff <= 1'b0;
      timer_b_q_ff <= 1'b0;
    end else begin
      one_sec_q_ff <= one_second_flag;
      timer_a_q_ff <= timer_a_flag;
      timer_b_q_ff <= timer_b_flag;
    end
  end

  wire src_mfsync = mfsync_lost & irq_mask3_ff[MFSYNC_BIT];
  wire src_crc_mf = crc_mfsync_lost & irq_mask3_ff[CRC_MFSYNC_BIT];
  wire src_remote = remote_mf_alarm & irq_mask3_ff[REMOTE_MF_BIT];
  wire src_one_sec = rose(one_second_flag, one_sec_q_ff) & irq_mask3_ff[ONE_SEC_BIT];
  wire src_timer_a = rose(timer_a_flag, timer_a_q_ff) & irq_mask3_ff[TIMER_A_BIT];
  wire src_timer_b = rose(timer_b_flag, timer_b_q_ff) & irq_mask3_ff[TIMER_B_BIT];

  wire set_sync = src_mfsync | src_crc_mf | src_remote;
  wire set_timing = src_one_sec | src_timer_a | src_timer_b;
  wire [7:0] vec_set = (set_sync ? VEC_SYNC : 8'h00) | (set_timing ? VEC_TIMING : 8'h00);

  // Pending vector bits stick until acknowledged; a new event beats the acknowledge.
  wire [7:0] nxt_vector = (irq_ack ? 8'h00 : irq_vector_ff) | vec_set;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_vector_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      irq_vector_ff <= nxt_vector;
      irq_ff <= |nxt_vector;
    end
  end

  // ----------------------------------------
  // Single-shot error insertion
  // ----------------------------------------

  // rising writes only
  // A write that keeps, clears or sets an already set bit arms nothing.
  wire arm_line = wr_err & rose(host_req.data[LINE_VIOL_BIT], err_dbnc_ff[LINE_VIOL_BIT]);
  wire arm_crc = wr_err & rose(host_req.data[CRC_ERR_BIT], err_dbnc_ff[CRC_ERR_BIT]);
  wire arm_align = wr_err & rose(host_req.data[ALIGN_ERR_BIT], err_dbnc_ff[ALIGN_ERR_BIT]);
  wire arm_nonalign = wr_err & rose(host_req.data[NONALIGN_ERR_BIT], err_dbnc_ff[NONALIGN_ERR_BIT]);
  wire arm_payload = wr_err & rose(host_req.data[PAYLOAD_ERR_BIT], err_dbnc_ff[PAYLOAD_ERR_BIT]);

  logic [4:0] armed_ff;
  // Bit order of the armed vector: line, crc, align, nonalign, payload.
  wire [4:0] arm_vec = {arm_line, arm_crc, arm_align, arm_nonalign, arm_payload};
  wire [4:0] slot_vec = {tx_slots.line_slot, tx_slots.crc_slot, tx_slots.align_slot,
                         tx_slots.nonalign_slot, tx_slots.payload_slot};

  // fire at next slot
  // A request waits for its framer slot; a fresh arm in the firing cycle survives.
  wire [4:0] fire_vec = armed_ff & slot_vec;
  wire [4:0] nxt_armed = (armed_ff & ~fire_vec) | arm_vec;
  always_ff @(posedge ref_clk) begin
    if (rst) armed_ff <= 5'h00;
    else armed_ff <= nxt_armed;
  end

  logic [4:0] fire_ff;
  // Registered one-cycle insertion pulses toward the transmit framer.
  always_ff @(posedge ref_clk) begin
    if (rst) fire_ff <= 5'h00;
    else fire_ff <= fire_vec;
  end

  assign insert_line_violation = fire_ff[4];
  assign insert_crc_error = fire_ff[3];
  assign insert_align_error = fire_ff[2];
  assign insert_nonalign_error = fire_ff[1];
  assign insert_payload_error = fire_ff[0];
  assign force_no_pulses = err_dbnc_ff[NO_PULSE_BIT];

  // ----------------------------------------
  // Signalling debounce
  // ----------------------------------------
  logic [3:0] sig_sample_ff;
  logic [DEBOUNCE_CNT_W-1:0] dbnc_cnt_ff;

  // multiframe sampling
  // Signalling is only looked at once per multiframe, which can add up to one
  // multiframe (2 ms) of delay; this is accepted rather than sampling every bit.
  always_ff @(posedge ref_clk) begin
    if (rst) sig_sample_ff <= 4'h0;
    else if (sig_mf_tick) sig_sample_ff <= sig_raw;
  end

  wire dbnc_on = err_dbnc_ff[DEBOUNCE_SEL_BIT];
  wire sig_differs = sig_sample_ff != sig_debounced_ff;
  wire dbnc_done = dbnc_cnt_ff == DEBOUNCE_CNT_W'(DEBOUNCE_LEN - 1);

  // debounce select
  // With debounce off the sample passes straight; with it on a change must hold 14 ms.
  logic [DEBOUNCE_CNT_W-1:0] nxt_dbnc_cnt;
  logic [3:0] nxt_sig_out;
  always_comb begin
    nxt_dbnc_cnt = '0;
    nxt_sig_out = sig_debounced_ff;
    if (!dbnc_on) begin
      nxt_sig_out = sig_sample_ff;
    end else if (sig_differs) begin
      if (dbnc_done) begin
        nxt_sig_out = sig_sample_ff;
      end else begin
        nxt_dbnc_cnt = dbnc_cnt_ff + DEBOUNCE_CNT_W'(1);
      end
    end
  end

  // Counter restarts whenever the sample agrees again with the output.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dbnc_cnt_ff <= '0;
      sig_debounced_ff <= 4'h0;
    end else begin
      dbnc_cnt_ff <= nxt_dbnc_cnt;
      sig_debounced_ff <= nxt_sig_out;
    end
  end

endmodule

`default_nettype wire

// ### test/eim_host_model.sv
// Purpose: Host side of the register port, one strobe per access.
// Assumes: Requests change at falling edges of ref_clk.
// Notes: Released lines carry the inverse of the last value.
`default_nettype none

module eim_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] rd_data_ff,
  output var eim_pkg::eim_host_req_t host_req
);
  import eim_pkg::*;
  // ----------------------------------------
  // Register access tasks
  // ----------------------------------------
  // Port starts idle so no stray strobe reaches the bank during reset.
  initial host_req = '0;

  task automatic wr_reg(input logic [2:0] pg, input logic [4:0] ad, input logic [7:0] dt);
    logic [7:0] d;
    d = dt;
    if (pg == PAGE_MASK && ad == ADDR_TX_PULSE) d = d & 8'h0F;
    if (pg == PAGE_CTRL2 && (ad == ADDR_RSVD_A || ad == ADDR_RSVD_B)) d = 8'h00;
    @(negedge ref_clk);
    host_req <= '{1'b1, 1'b0, pg, ad, d};
    @(negedge ref_clk);
    host_req <= '{1'b0, 1'b0, ~pg, ~ad, ~d};
  endtask

  task automatic rd_reg(input logic [2:0] pg, input logic [4:0] ad, output logic [7:0] dt);
    @(negedge ref_clk);
    host_req <= '{1'b0, 1'b1, pg, ad, 8'h00};
    @(negedge ref_clk);
    dt = rd_data_ff;
    host_req <= '{1'b0, 1'b0, ~pg, ~ad, 8'hFF};
  endtask
endmodule

`default_nettype wire

// ### test/eim_bank_properties.sv
// Purpose: Port-level properties of the mask, pulse and insertion bank.
// Assumes: One clock, synchronous active-high reset.
// Notes: The mask word is mirrored from host writes to judge interrupts.
`default_nettype none

module eim_bank_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire eim_pkg::eim_host_req_t host_req,
  input wire logic [7:0] rd_data_ff,
  input wire logic mfsync_lost,
  input wire logic crc_mfsync_lost,
  input wire logic remote_mf_alarm,
  input wire logic one_second_flag,
  input wire logic timer_a_flag,
  input wire logic timer_b_flag,
  input wire logic irq_ack,
  input wire logic irq_ff,
  input wire logic [7:0] irq_vector_ff,
  input wire logic custom_pulse_sel,
  input wire logic [2:0] preset_pulse_level,
  input wire eim_pkg::eim_tx_slots_t tx_slots,
  input wire logic insert_line_violation,
  input wire logic insert_crc_error,
  input wire logic force_no_pulses
);
  import eim_pkg::*;
  // ----------------------------------------
  // Helper decode and mask mirror
  // ----------------------------------------
  logic [7:0] mask_ff;
  wire logic p1 = host_req.page == PAGE_MASK;
  wire logic p2 = host_req.page == PAGE_CTRL2;
  wire logic sync_any = mfsync_lost || crc_mfsync_lost || remote_mf_alarm;
  wire logic flag_any = one_second_flag || timer_a_flag || timer_b_flag;
  wire logic sync_ev = (mfsync_lost && mask_ff[7]) || (crc_mfsync_lost && mask_ff[6]) ||
    (remote_mf_alarm && mask_ff[4]);

  // Mirror only writable mask bits so readback compares need no extra masking.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_ff <= REG_RESET;
    end else if (host_req.wr && p1 && host_req.addr == ADDR_IRQ_MASK3) begin
      mask_ff <= host_req.data & IRQ_MASK3_WMASK;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_sync_vec_set: assert property (sync_ev |=> irq_vector_ff[7] && irq_ff)
    else $error("sync event did not set vector bit 7");
  a_timing_vec_set: assert property (($rose(one_second_flag) && mask_ff[3]) ||
    ($rose(timer_a_flag) && mask_ff[2]) || ($rose(timer_b_flag) && mask_ff[1]) |-> ##[1:2] irq_vector_ff[3])
    else $error("flag rise did not set vector bit 3");
  a_ack_clears: assert property (irq_ack && !sync_any && !flag_any |=> irq_vector_ff == 8'h00 && !irq_ff)
    else $error("acknowledge left a vector bit pending");
  a_mask_readback: assert property (host_req.rd && p1 && host_req.addr == ADDR_IRQ_MASK3 |=>
    rd_data_ff == $past(mask_ff)) else $error("mask readback wrong");
  a_pulse_ctrl: assert property (host_req.wr && p1 && host_req.addr == ADDR_TX_PULSE |=>
    custom_pulse_sel == $past(host_req.data[3]) && preset_pulse_level == $past(host_req.data[2:0]))
    else $error("pulse control outputs wrong");
  a_unmapped_read: assert property (host_req.rd && !p1 && !p2 |=> rd_data_ff == 8'h00)
    else $error("unmapped read not zero");
  a_line_at_slot: assert property (insert_line_violation |-> $past(tx_slots.line_slot))
    else $error("violation inserted outside a slot");
  a_crc_one_shot: assert property (insert_crc_error |=> !insert_crc_error)
    else $error("crc insertion longer than one cycle");
  a_no_pulse_lvl: assert property (host_req.wr && p2 && host_req.addr == ADDR_ERR_DBNC |=>
    force_no_pulses == $past(host_req.data[3])) else $error("no-pulse level wrong");
endmodule

bind eim_bank eim_bank_properties u_props (.ref_clk(ref_clk), .rst(rst), .host_req(host_req),
  .rd_data_ff(rd_data_ff), .mfsync_lost(mfsync_lost), .crc_mfsync_lost(crc_mfsync_lost),
  .remote_mf_alarm(remote_mf_alarm), .one_second_flag(one_second_flag), .timer_a_flag(timer_a_flag),
  .timer_b_flag(timer_b_flag), .irq_ack(irq_ack), .irq_ff(irq_ff), .irq_vector_ff(irq_vector_ff),
  .custom_pulse_sel(custom_pulse_sel), .preset_pulse_level(preset_pulse_level), .tx_slots(tx_slots),
  .insert_line_violation(insert_line_violation), .insert_crc_error(insert_crc_error),
  .force_no_pulses(force_no_pulses));

`default_nettype wire

// ### test/tb_top.sv
// Purpose: Self-checking bench for the mask, pulse and insertion bank.
// Assumes: All inputs change at falling edges of ref_clk.
// Notes: Debounce length is cut to 20 cycles to keep the run short.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eim_pkg::*;
  typedef struct packed {logic [2:0] pg; logic [4:0] ad; logic [7:0] wd; logic [7:0] ex;} eim_row_t;
  // ----------------------------------------
  // Stimulus, instances and checks
  // ----------------------------------------
  localparam eim_row_t ROWS [12] = '{'{3'h1, 5'h1E, 8'hFF, 8'hDE}, '{3'h1, 5'h1F, 8'hFB, 8'h0B},
    '{3'h2, 5'h13, 8'hA5, 8'hA5}, '{3'h2, 5'h18, 8'h5A, 8'h5A}, '{3'h2, 5'h19, 8'h3C, 8'h3C},
    '{3'h2, 5'h1C, 8'hFF, 8'h7F}, '{3'h2, 5'h1D, 8'h80, 8'h00}, '{3'h2, 5'h1E, 8'h55, 8'h55},
    '{3'h2, 5'h1F, 8'h2A, 8'h2A}, '{3'h2, 5'h11, 8'hFF, 8'h00}, '{3'h2, 5'h1A, 8'h77, 8'h00},
    '{3'h3, 5'h1E, 8'hFF, 8'h00}};
  logic ref_clk = 1'b0, rst = 1'b1, irq_ack = 1'b0, sig_mf_tick = 1'b0;
  logic [5:0] ev = '0;
  logic [3:0] sig_raw = '0, sig_debounced_ff;
  eim_tx_slots_t tx_slots = '0;
  eim_host_req_t host_req;
  logic [7:0] rd_data_ff, irq_vector_ff, access_ctrl_out, jitter_ctrl_out, rx_eq_ctrl_out, rd;
  logic [6:0] pulse_coef_a, pulse_coef_b, pulse_coef_c, pulse_coef_d;
  wire logic [4:0] ins;
  logic [2:0] preset_pulse_level;
  logic irq_ff, custom_pulse_sel, force_no_pulses;
  int err_count = 0, n_tests = 0, cnt [5];

  eim_host_model u_host (.ref_clk(ref_clk), .rd_data_ff(rd_data_ff), .host_req(host_req));
  eim_bank #(.DEBOUNCE_LEN(20)) u_dut (.ref_clk(ref_clk), .rst(rst), .host_req(host_req),
    .rd_data_ff(rd_data_ff), .mfsync_lost(ev[0]), .crc_mfsync_lost(ev[1]), .remote_mf_alarm(ev[2]),
    .one_second_flag(ev[3]), .timer_a_flag(ev[4]), .timer_b_flag(ev[5]), .irq_ack(irq_ack),
    .irq_ff(irq_ff), .irq_vector_ff(irq_vector_ff), .custom_pulse_sel(custom_pulse_sel),
    .preset_pulse_level(preset_pulse_level), .pulse_coef_a(pulse_coef_a), .pulse_coef_b(pulse_coef_b),
    .pulse_coef_c(pulse_coef_c), .pulse_coef_d(pulse_coef_d), .tx_slots(tx_slots),
    .insert_line_violation(ins[4]), .insert_crc_error(ins[3]),
    .insert_align_error(ins[2]), .insert_nonalign_error(ins[1]), .insert_payload_error(ins[0]),
    .force_no_pulses(force_no_pulses), .access_ctrl_out(access_ctrl_out), .jitter_ctrl_out(jitter_ctrl_out),
    .rx_eq_ctrl_out(rx_eq_ctrl_out), .sig_mf_tick(sig_mf_tick), .sig_raw(sig_raw),
    .sig_debounced_ff(sig_debounced_ff));

  // Free-running clock; insertion pulses are tallied so a double shot is seen.
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) for (int i = 0; i < 5; i++) if (ins[i] === 1'b1) cnt[i]++;

  task automatic check(input logic [7:0] got, input logic [7:0] ex, input string what);
    n_tests++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, ex);
    end
  endtask

  task automatic rdchk(input logic [2:0] pg, input logic [4:0] ad, input logic [7:0] ex);
    u_host.rd_reg(pg, ad, rd);
    check(rd, ex, "register read");
  endtask

  // Slots stay open four cycles, long enough to catch a repeated insertion.
  task automatic burst(input logic [7:0] wd, input logic [4:0] ex);
    u_host.wr_reg(PAGE_CTRL2, ADDR_ERR_DBNC, wd);
    cnt = '{0, 0, 0, 0, 0};
    tx_slots = '1;
    repeat (4) @(negedge ref_clk);
    tx_slots = '0;
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 5; i++) check(8'(cnt[i]), {7'h0, ex[i]}, "insert count");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset values, register rows, then the awkward cases.
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    foreach (ROWS[k]) rdchk(ROWS[k].pg, ROWS[k].ad, 8'h00);
    $display("reset test done");
    foreach (ROWS[k]) u_host.wr_reg(ROWS[k].pg, ROWS[k].ad, ROWS[k].wd);
    foreach (ROWS[k]) rdchk(ROWS[k].pg, ROWS[k].ad, ROWS[k].ex);
    check({custom_pulse_sel, preset_pulse_level, 1'b0, pulse_coef_c[2:0]}, 8'hB5, "pulse outputs");
    check(access_ctrl_out, 8'hA5, "access output");
    check(jitter_ctrl_out, 8'h5A, "jitter output");
    check(rx_eq_ctrl_out, 8'h3C, "equalizer output");
    check({1'b0, pulse_coef_a}, 8'h7F, "coef a output");
    check({1'b0, pulse_coef_b}, 8'h00, "coef b output");
    check({1'b0, pulse_coef_d}, 8'h2A, "coef d output");
    $display("register rows done");
    for (int i = 0; i < 6; i++) begin
      @(negedge ref_clk) ev[i] = 1'b1;
      @(negedge ref_clk) ev[i] = (i > 2);
      @(negedge ref_clk) check(irq_vector_ff, (i < 3) ? VEC_SYNC : VEC_TIMING, "vector");
      check({7'h0, irq_ff}, 8'h01, "irq level");
      ev[i] = 1'b0;
      @(negedge ref_clk) irq_ack = 1'b1;
      @(negedge ref_clk) irq_ack = 1'b0;
      @(negedge ref_clk) check(irq_vector_ff, 8'h00, "vector after ack");
    end
    u_host.wr_reg(PAGE_MASK, ADDR_IRQ_MASK3, 8'h00);
    @(negedge ref_clk) ev = 6'h09;
    @(negedge ref_clk) ev = '0;
    @(negedge ref_clk) check(irq_vector_ff, 8'h00, "masked events");
    $display("interrupt test done");
    burst(8'hC0, 5'b11000);
    burst(8'hC0, 5'b00000);
    burst(8'h00, 5'b00000);
    burst(8'h34, 5'b00111);
    burst(8'h08, 5'b00000);
    check({7'h0, force_no_pulses}, 8'h01, "no pulses");
    $display("insertion test done");
    @(negedge ref_clk) {sig_raw, sig_mf_tick} = 5'b01011;
    @(negedge ref_clk) sig_mf_tick = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({4'h0, sig_debounced_ff}, 8'h05, "no debounce");
    u_host.wr_reg(PAGE_CTRL2, ADDR_ERR_DBNC, 8'h01);
    check({7'h0, force_no_pulses}, 8'h00, "pulses back");
    @(negedge ref_clk) {sig_raw, sig_mf_tick} = 5'b10101;
    @(negedge ref_clk) sig_mf_tick = 1'b0;
    repeat (9) @(negedge ref_clk);
    check({4'h0, sig_debounced_ff}, 8'h05, "debounce hold");
    repeat (30) @(negedge ref_clk);
    check({4'h0, sig_debounced_ff}, 8'h0A, "debounce done");
    $display("debounce test done");
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    rdchk(PAGE_MASK, ADDR_IRQ_MASK3, 8'h00);
    rdchk(PAGE_CTRL2, ADDR_ERR_DBNC, 8'h00);
    check({4'h0, sig_debounced_ff}, 8'h00, "debounce after reset");
    $display("second reset done");
    finish_test();
  end

  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    #100us;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule

`default_nettype wire
